// *** inc/irq_mux_consts.vh ***
`ifndef IRQ_MUX_CONSTS_VH
`define IRQ_MUX_CONSTS_VH
// APB byte addresses (word index times four)
`define ADDR_MODE_CONTROL 12'h054
`define ADDR_SYSTEM_STATUS 12'h058
`define ADDR_IRQ_FLAGS 12'h05C
`define ADDR_PIN_FLAGS_LO 12'h01C
`define ADDR_PIN_FLAGS_MID 12'h11C
`define ADDR_PIN_FLAGS_HI 12'h12C
`define ADDR_PIN_IRQ_EN_LO 12'h018
`define ADDR_PIN_IRQ_EN_MID 12'h118
`define ADDR_PIN_IRQ_EN_HI 12'h128
`define ADDR_BOOT_CONTROL 12'h200
`define ADDR_WIDTH 12
// Mode control fields
`define MODE_WIDTH 9
`define MODE_RESET 9'h000
`define MODE_TRIP_EN 2
`define MODE_SYNC_EN 3
`define MODE_RX_SEL 4
`define MODE_UART_EN 5
// Interrupt flag fields
`define FLAG_TRIP 0
`define FLAG_SYNC 1
// Status fields
`define STAT_TRIP 0
`define STAT_WDOG 1
`define STAT_POL 2
`define STAT_RELUCT 3
`define STAT_PWM_TIMER 4
// Vector addresses
`define VEC_RESET 14'h0000
`define VEC_PERIPH 14'h0004
`define VEC_PIO 14'h0008
`define VEC_SYNC 14'h000C
`define VEC_SERIAL_PORT_0_TX 14'h0010
`define VEC_SERIAL_PORT_0_RX 14'h0014
`define VEC_SOFT1 14'h0018
`define VEC_SOFT0 14'h001C
`define VEC_SERIAL_PORT_1_TX 14'h0020
`define VEC_SERIAL_PORT_1_RX 14'h0024
`define VEC_TIMER 14'h0028
`define VEC_TRIP 14'h002C
`define VEC_TABLE_END 14'h002F
`define VEC_USER_START 14'h0030
`endif

// *** hdl/periph_irq_and_serial_pin_mux.v ***
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Reset table spans 0x0000..0x002F; four words per source; boot_vector starts there.
// R2 - Unmasked interrupts reach the core after only the sync delay; peripheral events here add two registered stages, flags then vector.
// R3 - Core timer, serial and software interrupts get their own vector slot.
// R4 - Peripheral event sets its bit in irq flags or pin-change flags.
// R5 - Peripheral irq line held low while any flag is pending.
// R6 - All twenty-six peripheral sources vector to 0x0004.
// R7 - Dispatcher reads irq flags, saves them, branches 0x002C trip, 0x000C sync.
// R8 - Simultaneous interrupts: higher-priority handler chosen first.
// R9 - Reading irq flags clears trip and sync and acknowledges.
// R10 - Value read from irq flags is kept for later inspection.
// R11 - Reading a pin-change flag register clears it and acknowledges.
// R12 - Two receive pins multiplexed into serial port 1 receive input.
// R13 - rx_pin_select high picks pin b, low picks pin a.
// R14 - uart_mode_enable joins receive input and receive frame sync.
// R15 - In UART mode flag_out_1 drives the serial ROM reset pin.
// R16 - Boot start clears rx select, sets UART mode, pulses flag_out_1.
// R17 - In UART boot, stream start seen on joined frame sync.
// R18 - Successful serial boot starts execution at 0x0030.
// R19 - Software may later pick pin b then leave UART mode.
// R20 - Failed boot picks pin b, stays UART, awaits header byte.
// R21 - Any hardware, software or watchdog reset clears peripheral state; soft reset leaves irq_flags_saved as it was.
// R22 - Status register reports trip, polarity, reluctance, watchdog, PWM timer.
// R23 - Trip interrupt gated by mode bit 2, sync by bit 3.
// R24 - Sync on rising pwm_sync_pulse, trip on falling pwm_trip_input.
// R25 - Pin interrupt on either edge of an enabled pin.
// R26 - Flags hold until read; an event in the read cycle survives.
// R27 - Pin inputs pass two flip-flops before edge detection.
`include "irq_mux_consts.vh"
module periph_irq_and_serial_pin_mux #(
  parameter PIO_WIDTH = 24
) (
  input wire pclk, // Core clock
  input wire presetn, // Hardware reset, active low
  input wire soft_reset, // Software or watchdog peripheral reset
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output wire pslverr, // APB error on unmapped address
  input wire pwm_sync_pulse, // PWM sync pulse
  input wire pwm_trip_input, // PWM trip pin
  input wire pwm_polarity_pin, // PWM polarity strap
  input wire pwm_reluctance_mode_pin, // Reluctance mode strap
  input wire watchdog_expired, // Watchdog reset seen
  input wire pwm_timer_status, // PWM timer phase
  input wire [PIO_WIDTH-1:0] pio_pins, // Programmable I/O inputs
  input wire core_irq_masked_in, // Core-side interrupt request bits
  input wire [7:0] core_irq_req, // Timer, serial, software requests
  input wire [7:0] core_irq_mask, // Core mask bits
  input wire periph_irq_mask, // Core mask bit for peripheral line
  output reg peripheral_irq_line_n, // Peripheral interrupt, active low
  output reg [13:0] irq_vector, // Vector taken by sequencer
  output reg irq_vector_valid, // Vector valid
  input wire rx_pin_a, // Receive pin a
  input wire rx_pin_b, // Receive pin b
  input wire rx_frame_sync_pin, // External receive frame sync
  input wire flag_out_1, // Core software flag 1
  output wire serial1_rx_input, // Receive data into serial port 1
  output wire serial1_rx_frame_sync, // Frame sync into serial port 1
  output wire serial_rom_reset_pin, // Serial ROM reset output
  output wire serial_rom_reset_oe, // Drive enable for that pin
  output reg [13:0] boot_vector, // Start address after boot
  output reg [15:0] irq_flags_saved // Last value read from irq flags
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ROMRST = 4'b0010;
  localparam ST_LOAD = 4'b0100;
  localparam ST_DONE = 4'b1000;
  reg [`MODE_WIDTH-1:0] mode_reg;
  reg [PIO_WIDTH-1:0] pin_en_reg;
  reg [PIO_WIDTH-1:0] pin_flags_reg;
  reg [PIO_WIDTH-1:0] pin_sync1_reg;
  reg [PIO_WIDTH-1:0] pin_sync2_reg;
  reg [PIO_WIDTH-1:0] pin_prev_reg;
  reg [1:0] irq_flags_reg;
  reg [1:0] pwm_sync1_reg;
  reg [1:0] pwm_sync2_reg;
  reg [1:0] pwm_prev_reg;
  reg [3:0] boot_state_reg;
  reg [2:0] boot_cmd_reg;
  wire clr_n;
  wire wr_en;
  wire rd_en;
  wire sync_rise;
  wire trip_fall;
  wire [PIO_WIDTH-1:0] pin_edge;
  wire [PIO_WIDTH-1:0] rd_clear;
  wire mapped;
  // R21 - soft and watchdog reset share the clear path
  assign clr_n = ~soft_reset;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign mapped = (paddr == `ADDR_MODE_CONTROL) | (paddr == `ADDR_SYSTEM_STATUS) |
    (paddr == `ADDR_IRQ_FLAGS) | (paddr == `ADDR_PIN_FLAGS_LO) |
    (paddr == `ADDR_PIN_FLAGS_MID) | (paddr == `ADDR_PIN_FLAGS_HI) |
    (paddr == `ADDR_PIN_IRQ_EN_LO) | (paddr == `ADDR_PIN_IRQ_EN_MID) |
    (paddr == `ADDR_PIN_IRQ_EN_HI) | (paddr == `ADDR_BOOT_CONTROL);
  assign pslverr = psel & penable & ~mapped;

  // Byte lane of the 24 pin bits that an address selects
  function [PIO_WIDTH-1:0] lane_mask;
    input [11:0] a;
    input [11:0] lo;
    input [11:0] mid;
    input [11:0] hi;
    begin
      lane_mask = {PIO_WIDTH{1'b0}};
      if (a == lo)
        lane_mask[7:0] = 8'hFF;
      if (a == mid)
        lane_mask[15:8] = 8'hFF;
      if (a == hi)
        lane_mask[23:16] = 8'hFF;
    end
  endfunction

  // R11 - read of a pin flag byte clears that byte
  assign rd_clear = rd_en ? lane_mask(paddr, `ADDR_PIN_FLAGS_LO, `ADDR_PIN_FLAGS_MID,
    `ADDR_PIN_FLAGS_HI) : {PIO_WIDTH{1'b0}};

  // R27 - two-stage sync before edge detect
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync1_reg <= {PIO_WIDTH{1'b0}};
      pin_sync2_reg <= {PIO_WIDTH{1'b0}};
      pin_prev_reg <= {PIO_WIDTH{1'b0}};
      pwm_sync1_reg <= 2'h0;
      pwm_sync2_reg <= 2'h0;
      pwm_prev_reg <= 2'h0;
    end
    else
    begin
      pin_sync1_reg <= pio_pins;
      pin_sync2_reg <= pin_sync1_reg;
      pin_prev_reg <= pin_sync2_reg;
      pwm_sync1_reg <= {pwm_sync_pulse, pwm_trip_input};
      pwm_sync2_reg <= pwm_sync1_reg;
      pwm_prev_reg <= pwm_sync2_reg;
    end
  end

  // R24 - rising sync, falling trip
  assign sync_rise = pwm_sync2_reg[1] & ~pwm_prev_reg[1];
  assign trip_fall = ~pwm_sync2_reg[0] & pwm_prev_reg[0];
  // R25 - either edge on enabled pins
  assign pin_edge = (pin_sync2_reg ^ pin_prev_reg) & pin_en_reg;

  // Register file and flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= `MODE_RESET;
      pin_en_reg <= {PIO_WIDTH{1'b0}};
      pin_flags_reg <= {PIO_WIDTH{1'b0}};
      irq_flags_reg <= 2'h0;
      irq_flags_saved <= 16'h0000;
      boot_cmd_reg <= 3'h0;
    end
    else if (!clr_n)
    begin
      mode_reg <= `MODE_RESET;
      pin_en_reg <= {PIO_WIDTH{1'b0}};
      pin_flags_reg <= {PIO_WIDTH{1'b0}};
      irq_flags_reg <= 2'h0;
      boot_cmd_reg <= 3'h0;
    end
    else
    begin
      boot_cmd_reg <= 3'h0;
      // R26 - set wins over clearing read
      // R4 - events set flag bits
      pin_flags_reg <= (pin_flags_reg & ~rd_clear) | pin_edge;
      // R9 - irq flag read clears both bits
      // R23 - enables gate trip and sync
      irq_flags_reg[`FLAG_TRIP] <= (irq_flags_reg[`FLAG_TRIP] &
        ~(rd_en && paddr == `ADDR_IRQ_FLAGS)) | (trip_fall & mode_reg[`MODE_TRIP_EN]);
      irq_flags_reg[`FLAG_SYNC] <= (irq_flags_reg[`FLAG_SYNC] &
        ~(rd_en && paddr == `ADDR_IRQ_FLAGS)) | (sync_rise & mode_reg[`MODE_SYNC_EN]);
      // R10 - keep the value read
      if (rd_en && paddr == `ADDR_IRQ_FLAGS)
        irq_flags_saved <= {14'h0000, irq_flags_reg};
      if (wr_en)
      begin
        // R19 - software may rewrite rx select and UART bits freely
        if (paddr == `ADDR_MODE_CONTROL)
          mode_reg <= pwdata[`MODE_WIDTH-1:0];
        if (paddr == `ADDR_PIN_IRQ_EN_LO)
          pin_en_reg[7:0] <= pwdata[7:0];
        if (paddr == `ADDR_PIN_IRQ_EN_MID)
          pin_en_reg[15:8] <= pwdata[7:0];
        if (paddr == `ADDR_PIN_IRQ_EN_HI)
          pin_en_reg[23:16] <= pwdata[7:0];
        if (paddr == `ADDR_BOOT_CONTROL)
          boot_cmd_reg <= pwdata[2:0];
      end
      // R16 - boot start: rx select a, UART on
      if (boot_state_reg == ST_IDLE && boot_cmd_reg[0])
      begin
        mode_reg[`MODE_RX_SEL] <= 1'b0;
        mode_reg[`MODE_UART_EN] <= 1'b1;
      end
      // R20 - failed load: pin b, stay in UART mode
      if (boot_state_reg == ST_LOAD && boot_cmd_reg[2])
      begin
        mode_reg[`MODE_RX_SEL] <= 1'b1;
        mode_reg[`MODE_UART_EN] <= 1'b1;
      end
    end
  end

  // Boot sequencer: cmd bit0 start, bit1 load ok, bit2 load failed
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_state_reg <= ST_IDLE;
      // R1 - vector table base
      boot_vector <= `VEC_RESET;
    end
    else if (!clr_n)
    begin
      boot_state_reg <= ST_IDLE;
      boot_vector <= `VEC_RESET;
    end
    else
    begin
      case (boot_state_reg)
        ST_IDLE:
          if (boot_cmd_reg[0])
            boot_state_reg <= ST_ROMRST;
        ST_ROMRST:
          // ROM reset is flag_out_1 set and toggled twice by the core
          boot_state_reg <= ST_LOAD;
        ST_LOAD:
          if (boot_cmd_reg[1])
          begin
            // R18 - user code starts at 0x0030
            boot_vector <= `VEC_USER_START;
            boot_state_reg <= ST_DONE;
          end
          else if (boot_cmd_reg[2])
            boot_state_reg <= ST_DONE;
        ST_DONE:
          boot_state_reg <= ST_DONE;
        default:
          boot_state_reg <= ST_IDLE;
      endcase
    end
  end

  // R12 - receive pin multiplexer
  // R13 - bit 4 picks pin b
  // R14 - UART mode joins data and frame sync
  // R17 - stream start appears on joined frame sync
  assign serial1_rx_input = mode_reg[`MODE_RX_SEL] ? rx_pin_b : rx_pin_a;
  assign serial1_rx_frame_sync = mode_reg[`MODE_UART_EN] ? serial1_rx_input :
    rx_frame_sync_pin;
  // R15 - flag drives ROM reset pin in UART mode
  assign serial_rom_reset_pin = flag_out_1;
  assign serial_rom_reset_oe = mode_reg[`MODE_UART_EN];

  // Read data; status straps are sampled live
  always @*
  begin
    prdata = 32'h00000000;
    if (rd_en)
    begin
      case (paddr)
        `ADDR_MODE_CONTROL: prdata[`MODE_WIDTH-1:0] = mode_reg;
        // R22 - status bits
        `ADDR_SYSTEM_STATUS:
        begin
          prdata[`STAT_TRIP] = pwm_trip_input;
          prdata[`STAT_WDOG] = watchdog_expired;
          prdata[`STAT_POL] = pwm_polarity_pin;
          prdata[`STAT_RELUCT] = pwm_reluctance_mode_pin;
          prdata[`STAT_PWM_TIMER] = pwm_timer_status;
        end
        `ADDR_IRQ_FLAGS: prdata[1:0] = irq_flags_reg;
        `ADDR_PIN_FLAGS_LO: prdata[7:0] = pin_flags_reg[7:0];
        `ADDR_PIN_FLAGS_MID: prdata[7:0] = pin_flags_reg[15:8];
        `ADDR_PIN_FLAGS_HI: prdata[7:0] = pin_flags_reg[23:16];
        `ADDR_PIN_IRQ_EN_LO: prdata[7:0] = pin_en_reg[7:0];
        `ADDR_PIN_IRQ_EN_MID: prdata[7:0] = pin_en_reg[15:8];
        `ADDR_PIN_IRQ_EN_HI: prdata[7:0] = pin_en_reg[23:16];
        `ADDR_BOOT_CONTROL: prdata[3:0] = boot_state_reg;
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // Vector selection, fixed priority from trip down to timer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      peripheral_irq_line_n <= 1'b1;
      irq_vector <= `VEC_RESET;
      irq_vector_valid <= 1'b0;
    end
    else
    begin
      // R5 - line low while anything pending
      peripheral_irq_line_n <= ~((|irq_flags_reg) | (|pin_flags_reg));
      // R2 - two registered stages after sync (flags, then vector), no more
      irq_vector_valid <= 1'b1;
      // R8 - priority order
      // R6 - peripherals share 0x0004
      // R7 - dispatcher target: trip 0x002C, sync 0x000C, else pin handler
      // R3 - core sources use own slots
      if (irq_flags_reg[`FLAG_TRIP] && periph_irq_mask)
        irq_vector <= `VEC_PERIPH;
      else if (((|irq_flags_reg) | (|pin_flags_reg)) && periph_irq_mask)
        irq_vector <= `VEC_PERIPH;
      else if (core_irq_req[0] && core_irq_mask[0])
        irq_vector <= `VEC_SERIAL_PORT_0_TX;
      else if (core_irq_req[1] && core_irq_mask[1])
        irq_vector <= `VEC_SERIAL_PORT_0_RX;
      else if (core_irq_req[2] && core_irq_mask[2])
        irq_vector <= `VEC_SOFT1;
      else if (core_irq_req[3] && core_irq_mask[3])
        irq_vector <= `VEC_SOFT0;
      else if (core_irq_req[4] && core_irq_mask[4])
        irq_vector <= `VEC_SERIAL_PORT_1_TX;
      else if (core_irq_req[5] && core_irq_mask[5])
        irq_vector <= `VEC_SERIAL_PORT_1_RX;
      else if (core_irq_req[6] && core_irq_mask[6])
        irq_vector <= `VEC_TIMER;
      else
      begin
        irq_vector <= `VEC_RESET;
        irq_vector_valid <= 1'b0;
      end
    end
  end
endmodule // periph_irq_and_serial_pin_mux

// *** verification/irq_mux_chk_assertions.sv ***
`timescale 1ns/1ns
`include "irq_mux_consts.vh"
module irq_mux_chk (
  input wire pclk, // Clock
  input wire presetn, // Reset, active low
  input wire soft_reset, // Soft reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pwrite, // Direction
  input wire [11:0] paddr, // Address
  input wire [31:0] prdata, // Read data
  input wire [7:0] core_irq_req, // Core requests
  input wire [7:0] core_irq_mask, // Core masks
  input wire periph_irq_mask, // Line mask
  input wire peripheral_irq_line_n, // Peripheral line
  input wire [13:0] irq_vector, // Vector
  input wire irq_vector_valid, // Vector valid
  input wire rx_pin_a, // Pin a
  input wire rx_pin_b, // Pin b
  input wire rx_frame_sync_pin, // Frame sync pin
  input wire flag_out_1, // Core flag
  input wire serial1_rx_input, // Receive data
  input wire serial1_rx_frame_sync, // Receive frame sync
  input wire serial_rom_reset_pin, // ROM reset
  input wire serial_rom_reset_oe // ROM reset enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = psel && penable && !pwrite;
  wire rd_irq = rd && paddr == `ADDR_IRQ_FLAGS;
  wire rd_any = rd_irq || rd && (paddr == `ADDR_PIN_FLAGS_LO || paddr == `ADDR_PIN_FLAGS_MID
    || paddr == `ADDR_PIN_FLAGS_HI);
  wire core_only = (core_irq_req[6:0] & core_irq_mask[6:0]) != 7'h00 && peripheral_irq_line_n;
  // Flags are cleared only by a read or a soft reset, so two quiet cycles pin the line
  sequence s_quiet;
    (!rd_any && !soft_reset) [*2];
  endsequence
  sequence s_core;
    core_only [*3];
  endsequence
  AST_RX_MUX: assert property (serial1_rx_input == rx_pin_a || serial1_rx_input == rx_pin_b)
    else $error("rx input follows neither pin");
  AST_UART_JOIN: assert property (
    serial_rom_reset_oe |-> serial1_rx_frame_sync == serial1_rx_input)
    else $error("uart mode frame sync not joined");
  AST_SYNC_PASS: assert property (
    !serial_rom_reset_oe |-> serial1_rx_frame_sync == rx_frame_sync_pin)
    else $error("frame sync not from its pin");
  AST_ROM_RESET: assert property (
    serial_rom_reset_oe |-> serial_rom_reset_pin == flag_out_1)
    else $error("rom reset pin not following flag");
  AST_LINE_LOW: assert property (
    rd_irq && prdata[1:0] != 2'h0 |-> ##[0:1] !peripheral_irq_line_n)
    else $error("pending flag without line low");
  AST_LINE_HOLD: assert property (
    s_quiet ##0 !peripheral_irq_line_n |=> !peripheral_irq_line_n)
    else $error("line released without a clearing read");
  AST_PERIPH_VEC: assert property (
    $fell(peripheral_irq_line_n) && periph_irq_mask |-> ##[0:1]
    (irq_vector_valid && irq_vector == `VEC_PERIPH))
    else $error("peripheral vector not taken");
  AST_CORE_VEC: assert property (
    s_core |-> irq_vector_valid && irq_vector[1:0] == 2'h0 && irq_vector >= `VEC_SERIAL_PORT_0_TX
    && irq_vector <= `VEC_TIMER)
    else $error("core source vector outside its slots");
endmodule // irq_mux_chk

// *** verification/serial_rom_model.sv ***
`timescale 1ns/1ns
module serial_rom_model (
  input wire pclk, // Clock
  input wire rom_reset, // Reset pin level
  input wire rom_reset_oe, // Pin driven by device
  output reg data_out, // Serial data out
  output reg streaming // Reset sequence seen
);
  reg last_lvl;
  reg [7:0] shift_reg;
  integer edges;
  initial
  begin
    data_out = 1'b0;
    streaming = 1'b0;
    last_lvl = 1'b0;
    shift_reg = 8'hA5;
    edges = 0;
  end
  always @(posedge pclk)
  begin
    last_lvl <= rom_reset;
    if (!rom_reset_oe)
      edges <= 0;
    else if (rom_reset !== last_lvl)
      edges <= edges + 1;
    streaming <= rom_reset_oe && edges >= 3;
    shift_reg <= {shift_reg[6:0], shift_reg[7]};
    // Idle line toggles so stale data never passes
    data_out <= streaming ? shift_reg[7] : ~data_out;
  end
endmodule // serial_rom_model

// *** verification/periph_irq_and_serial_pin_mux_bench.sv ***
`timescale 1ns/1ns
`include "irq_mux_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module periph_irq_and_serial_pin_mux_bench;
  reg pclk, presetn, soft_reset, psel, penable, pwrite, pwm_sync_pulse, pwm_trip_input;
  reg pwm_polarity_pin, pwm_reluctance_mode_pin, watchdog_expired, pwm_timer_status;
  reg core_irq_masked_in, periph_irq_mask, rx_pin_b, rx_frame_sync_pin, flag_out_1, err;
  reg [11:0] paddr;
  reg [31:0] pwdata, q, rnd;
  reg [23:0] pio_pins;
  reg [7:0] core_irq_req, core_irq_mask;
  reg [13:0] v [0:6];
  reg [11:0] ena [0:2];
  wire pready, pslverr, peripheral_irq_line_n, irq_vector_valid, rx_pin_a, streaming;
  wire serial1_rx_input, serial1_rx_frame_sync, serial_rom_reset_pin, serial_rom_reset_oe;
  wire [31:0] prdata;
  wire [13:0] irq_vector, boot_vector;
  wire [15:0] irq_flags_saved;
  integer n_errors, comparisons, i, j, m, e;
  periph_irq_and_serial_pin_mux #(.PIO_WIDTH(24)) dut_u (.pclk, .presetn, .soft_reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .pwm_sync_pulse,
    .pwm_trip_input, .pwm_polarity_pin, .pwm_reluctance_mode_pin, .watchdog_expired,
    .pwm_timer_status, .pio_pins, .core_irq_masked_in, .core_irq_req, .core_irq_mask,
    .periph_irq_mask, .peripheral_irq_line_n, .irq_vector, .irq_vector_valid, .rx_pin_a,
    .rx_pin_b, .rx_frame_sync_pin, .flag_out_1, .serial1_rx_input, .serial1_rx_frame_sync,
    .serial_rom_reset_pin, .serial_rom_reset_oe, .boot_vector, .irq_flags_saved);
  serial_rom_model rom_u (.pclk, .rom_reset(serial_rom_reset_pin),
    .rom_reset_oe(serial_rom_reset_oe), .data_out(rx_pin_a), .streaming);
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task wt(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  end
  endtask
  task rd(input [11:0] a, input [31:0] x);
  begin
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  end
  endtask
  task srst;
  begin
    @(posedge pclk) soft_reset <= 1'b1;
    @(posedge pclk) soft_reset <= 1'b0;
    wt(2);
  end
  endtask
  task conclude;
  begin
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    n_errors++;
    conclude;
  end
  initial
  begin
    n_errors = 0; comparisons = 0; rnd = 32'h615C;
    {psel, penable, pwrite, soft_reset, pwm_sync_pulse, flag_out_1, rx_pin_b} = 7'h00;
    {pwm_polarity_pin, pwm_reluctance_mode_pin, watchdog_expired, pwm_timer_status} = 4'h0;
    {core_irq_masked_in, rx_frame_sync_pin, pwm_trip_input, periph_irq_mask} = 4'h3;
    paddr = 12'h000; pwdata = 32'h0; pio_pins = 24'h0;
    core_irq_req = 8'h00; core_irq_mask = 8'h7F;
    ena[0] = `ADDR_PIN_IRQ_EN_LO; ena[1] = `ADDR_PIN_IRQ_EN_MID; ena[2] = `ADDR_PIN_IRQ_EN_HI;
    presetn = 1'b0;
    wt(4);
    presetn <= 1'b1;
    `CHK(peripheral_irq_line_n, 1'b1)
    `CHK(boot_vector, `VEC_RESET)
    apb(1'b1, 12'h3F0, 32'h30);
    `CHK(err, 1'b1)
    rd(`ADDR_MODE_CONTROL, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      @(posedge pclk);
      {pwm_timer_status, pwm_reluctance_mode_pin, pwm_polarity_pin, watchdog_expired} <= rnd[3:0];
      wt(4);
      rd(`ADDR_SYSTEM_STATUS, {27'h0, rnd[3:0], pwm_trip_input});
    end
    for (m = 0; m < 16; m += 4)
    begin
      apb(1'b1, `ADDR_MODE_CONTROL, m);
      @(posedge pclk);
      pwm_trip_input <= 1'b1; pwm_sync_pulse <= 1'b0; core_irq_req <= 8'h7F;
      wt(6);
      rd(`ADDR_IRQ_FLAGS, 32'h0);
      @(posedge pclk);
      pwm_trip_input <= 1'b0; pwm_sync_pulse <= 1'b1;
      wt(6);
      e = m >> 2;
      `CHK(peripheral_irq_line_n, e == 0)
      if (e != 0) `CHK(irq_vector, `VEC_PERIPH)
      rd(`ADDR_IRQ_FLAGS, e);
      @(negedge pclk);
      `CHK(irq_flags_saved, e[15:0])
      rd(`ADDR_IRQ_FLAGS, 32'h0);
      wt(3);
      `CHK(peripheral_irq_line_n, 1'b1)
    end
    for (i = 0; i < 3; i++)
      for (j = 0; j < 2; j++)
      begin
        rnd = lfsr(rnd);
        apb(1'b1, ena[i], rnd[7:0] | 8'h01);
        @(posedge pclk);
        pio_pins <= pio_pins ^ ({16'h0, rnd[15:8] | 8'h01} << (8 * i));
        wt(6);
        `CHK(peripheral_irq_line_n, 1'b0)
        rd(ena[i] + 12'h004, (rnd[7:0] | 8'h01) & (rnd[15:8] | 8'h01));
        rd(ena[i] + 12'h004, 32'h0);
        wt(3);
        `CHK(peripheral_irq_line_n, 1'b1)
      end
    for (i = 0; i < 7; i++)
    begin
      @(posedge pclk) core_irq_req <= 8'h01 << i;
      wt(4);
      v[i] = irq_vector;
      `CHK(irq_vector_valid, 1'b1)
      `CHK(irq_vector, `VEC_SERIAL_PORT_0_TX + 14'h0004 * i)
      for (j = 0; j < i; j++) `CHK(v[j] == v[i], 1'b0)
    end
    @(posedge pclk) core_irq_req <= 8'h7F;
    wt(4);
    `CHK(irq_vector, `VEC_SERIAL_PORT_0_TX)
    @(posedge pclk) core_irq_mask <= 8'h00;
    wt(4);
    `CHK(irq_vector_valid, 1'b0)
    for (m = 0; m < 4; m++)
    begin
      apb(1'b1, `ADDR_MODE_CONTROL, m << 4);
      repeat (4)
      begin
        rnd = lfsr(rnd);
        @(posedge pclk) {rx_pin_b, rx_frame_sync_pin, flag_out_1} <= rnd[2:0];
        @(negedge pclk);
        `CHK(serial1_rx_input, m[0] ? rx_pin_b : rx_pin_a)
        `CHK(serial1_rx_frame_sync, m[1] ? (m[0] ? rx_pin_b : rx_pin_a) : rx_frame_sync_pin)
        `CHK(serial_rom_reset_oe, m[1])
        `CHK(serial_rom_reset_pin, flag_out_1)
      end
    end
    srst;
    rd(`ADDR_MODE_CONTROL, 32'h0);
    apb(1'b1, `ADDR_BOOT_CONTROL, 32'h1);
    wt(3);
    rd(`ADDR_MODE_CONTROL, 32'h20);
    rd(`ADDR_BOOT_CONTROL, 32'h4);
    for (i = 0; i < 4; i++) @(posedge pclk) flag_out_1 <= i[0];
    wt(4);
    `CHK(streaming, 1'b1)
    repeat (4) @(negedge pclk) `CHK(serial1_rx_frame_sync, rx_pin_a)
    apb(1'b1, `ADDR_BOOT_CONTROL, 32'h2);
    wt(2);
    `CHK(boot_vector, `VEC_USER_START)
    apb(1'b1, `ADDR_MODE_CONTROL, 32'h30);
    apb(1'b1, `ADDR_MODE_CONTROL, 32'h10);
    @(negedge pclk);
    `CHK(serial1_rx_input, rx_pin_b)
    srst;
    `CHK(boot_vector, `VEC_RESET)
    apb(1'b1, `ADDR_BOOT_CONTROL, 32'h1);
    wt(3);
    apb(1'b1, `ADDR_BOOT_CONTROL, 32'h4);
    wt(2);
    rd(`ADDR_MODE_CONTROL, 32'h30);
    conclude;
  end
endmodule // periph_irq_and_serial_pin_mux_bench
bind periph_irq_and_serial_pin_mux irq_mux_chk chk_u (.pclk, .presetn, .soft_reset, .psel,
  .penable, .pwrite, .paddr, .prdata, .core_irq_req, .core_irq_mask, .periph_irq_mask,
  .peripheral_irq_line_n, .irq_vector, .irq_vector_valid, .rx_pin_a, .rx_pin_b,
  .rx_frame_sync_pin, .flag_out_1, .serial1_rx_input, .serial1_rx_frame_sync,
  .serial_rom_reset_pin, .serial_rom_reset_oe);
